//--- logic/lcs_sequencer.sv
// Colour line-scan output sequencer: register slave, exposure and tap sequencing
package lcs_pkg;
   localparam int PIX_W  = 12;
   localparam int WORD_W = 4 * PIX_W;
   localparam int AW     = 12;
   localparam int WW     = 13;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ROI  = 8'h04;
   localparam logic [7:0] REG_EXP  = 8'h08;
   localparam logic [7:0] REG_FVAL = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;

   // Field positions
   localparam int CTRL_RAW_BIT   = 0;
   localparam int CTRL_TAPS_LSB  = 1;
   localparam int CTRL_DEPTH_LSB = 4;
   localparam int CTRL_ROI_BIT   = 6;
   localparam int CTRL_MODEL_LSB = 7;
   localparam int ROI_START_LSB  = 0;
   localparam int ROI_LEN_LSB    = 16;
   localparam int STAT_MISS_BIT  = 5;

   // Reset values
   localparam logic [2:0]  TAPS_RST  = 3'h2;
   localparam logic [1:0]  DEPTH_RST = 2'h2;
   localparam logic [1:0]  MODEL_RST = 2'h2;
   localparam logic [15:0] EXP_RST   = 16'h0064;
   localparam logic [7:0]  FVAL_RST  = 8'h02;

   // Tap count codes
   localparam logic [2:0] TAPS_2 = 3'h0;
   localparam logic [2:0] TAPS_3 = 3'h1;
   localparam logic [2:0] TAPS_4 = 3'h2;
   localparam logic [2:0] TAPS_6 = 3'h3;
   localparam logic [2:0] TAPS_8 = 3'h4;

   // Bit depth codes
   localparam logic [1:0] DEPTH_8  = 2'h0;
   localparam logic [1:0] DEPTH_10 = 2'h1;

   // Virtual pixels (pixel pairs) per full line for each model code
   localparam logic [WW-1:0] WORDS_SMALL = 13'h0400;
   localparam logic [WW-1:0] WORDS_MID   = 13'h0800;
   localparam logic [WW-1:0] WORDS_WIDE  = 13'h1000;

   // Lanes of a stored pair word
   localparam int LANE_A_ODD  = 0;
   localparam int LANE_A_EVEN = 1;
   localparam int LANE_B_ODD  = 2;
   localparam int LANE_B_EVEN = 3;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_EXPOSE = 5'b00010,
      ST_READ   = 5'b00100,
      ST_SEND   = 5'b01000,
      ST_TAIL   = 5'b10000
   } lcs_state_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: RGB mode on 2,3,4,6,8 taps, 8/10/12 bits
// R2: Full line is 4096, 2048 or 1024 pixels
// R3: Window enable takes line length from window
// R4: Two taps: tap_one alternates pixel and dummy
// R5: Four taps: tap_three carries dummy
// R6: Eight taps: tap_three and tap_seven dummy
// R7: Valid bits and clock keep fixed positions
// R8: Tap bit mapping follows tap mode
// R9: Raw: both lines exposed, one sent per trigger
// R10: Raw: line A sent before line B
// R11: Odd trigger exposes, sends A, buffers B
// R12: Even trigger sends buffered B, no exposure
// R13: One exposure duration for both lines
// R14: Raw values ordered by pixel within line
// R15: Host moves image one pitch per exposure
// R16: Green is rounded-up mean of two greens
// R17: RGB order is red, green, blue per pixel
// R18: Frame valid rises with a line A
// R19: Frame valid length even lines, zero keeps low
// R20: Dummy slots are zero with data valid high
// R21: Three and six taps carry no dummies
module lcs_sequencer
   import lcs_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output var  logic              hreadyout,
   output var  logic [31:0]       hrdata,
   output var  logic              hresp,
   input  wire logic              line_trigger,
   input  wire logic              pixclk_in,
   input  wire logic              sen_valid,
   input  wire logic [2*PIX_W-1:0] sen_line_a,
   input  wire logic [2*PIX_W-1:0] sen_line_b,
   output var  logic              sen_expose,
   output var  logic              sen_read,
   output var  logic [PIX_W-1:0]  tap_zero,
   output var  logic [PIX_W-1:0]  tap_one,
   output var  logic [PIX_W-1:0]  tap_two,
   output var  logic [PIX_W-1:0]  tap_three,
   output var  logic [PIX_W-1:0]  tap_four,
   output var  logic [PIX_W-1:0]  tap_five,
   output var  logic [PIX_W-1:0]  tap_six,
   output var  logic [PIX_W-1:0]  tap_seven,
   output var  logic              line_valid,
   output var  logic              data_valid,
   output var  logic              frame_valid
);

   typedef logic [7:0][PIX_W-1:0]  lcs_taps_t;
   typedef logic [3:0][WORD_W-1:0] lcs_fetch_t;

   typedef struct packed {
      lcs_state_t       st;
      logic             bus_wr;
      logic [7:0]       bus_addr;
      logic [31:0]      rdata;
      logic             ready_o;
      logic             mode_raw;
      logic [2:0]       taps;
      logic [1:0]       depth;
      logic             roi_en;
      logic [1:0]       model;
      logic [WW-1:0]    roi_start;
      logic [WW-1:0]    roi_len;
      logic [15:0]      exp_time;
      logic [7:0]       fval_len;
      logic             trg_s1;
      logic             trg_s2;
      logic             trg_d;
      logic             pck_s1;
      logic             pck_s2;
      logic             pck_d;
      logic             next_b;
      logic             line_b;
      logic             missed;
      logic [15:0]      cnt;
      logic [AW-1:0]    wr_addr;
      logic [WW-1:0]    w;
      logic             ph;
      logic             primed;
      logic             first;
      logic             fetching;
      logic [2:0]       fcnt;
      logic             cap_v;
      logic [1:0]       cap_slot;
      logic             cap_in;
      lcs_fetch_t       fb;
      lcs_taps_t        tap;
      logic             lval;
      logic             dval;
      logic             fval;
      logic [7:0]       fcount;
      logic             expose;
      logic             sen_rd;
   } lcs_st_t;

   lcs_st_t r;
   lcs_st_t n;

   logic              mem_we;
   logic [AW-1:0]     mem_raddr;
   logic [WORD_W-1:0] mem_rdata;

   function automatic logic [WW-1:0] full_words(input logic [1:0] m);
      case (m)
         2'h0:    return WORDS_SMALL;
         2'h1:    return WORDS_MID;
         default: return WORDS_WIDE;
      endcase
   endfunction

   // Pair words consumed per pixel clock, or per two pixel clocks for two-tap RGB
   function automatic logic [2:0] words_per_clk(input logic raw, input logic [2:0] t);
      case (t)
         TAPS_4:  return raw ? 3'h2 : 3'h1;
         TAPS_6:  return 3'h2;
         TAPS_8:  return raw ? 3'h4 : 3'h2;
         default: return 3'h1;
      endcase
   endfunction

   function automatic logic [PIX_W-1:0] lane(input logic [WORD_W-1:0] wd, input int idx);
      return wd[idx*PIX_W +: PIX_W];
   endfunction

   function automatic logic [PIX_W-1:0] avg_green(input logic [PIX_W-1:0] a,
                                                  input logic [PIX_W-1:0] b);
      logic [PIX_W:0] s;
      s = {1'b0, a} + {1'b0, b} + 13'h0001; // R16
      return s[PIX_W:1];
   endfunction

   // Keeps the most significant bits of a 12-bit value at the chosen depth
   function automatic logic [PIX_W-1:0] scale(input logic [PIX_W-1:0] v, input logic [1:0] d);
      case (d)
         DEPTH_8:  return {4'h0, v[PIX_W-1:4]};
         DEPTH_10: return {2'h0, v[PIX_W-1:2]};
         default:  return v;
      endcase
   endfunction

   function automatic lcs_taps_t compose(input logic raw, input logic lb, input logic [2:0] t,
                                         input logic ph, input lcs_fetch_t fb,
                                         input logic [1:0] d);
      lcs_taps_t        o;
      logic [2:0]       kw;
      logic [PIX_W-1:0] rv [0:1];
      logic [PIX_W-1:0] gv [0:1];
      logic [PIX_W-1:0] bv [0:1];
      o  = '0;
      kw = words_per_clk(raw, t);
      for (int i = 0; i < 2; i++) begin
         rv[i] = lane(fb[i], LANE_A_ODD);
         gv[i] = avg_green(lane(fb[i], LANE_A_EVEN), lane(fb[i], LANE_B_ODD));
         bv[i] = lane(fb[i], LANE_B_EVEN);
      end
      if (raw) begin
         for (int s = 0; s < 4; s++) begin
            if (s < int'(kw)) begin
               o[2*s]   = lb ? lane(fb[s], LANE_B_ODD) : lane(fb[s], LANE_A_ODD); // R14
               o[2*s+1] = lb ? lane(fb[s], LANE_B_EVEN) : lane(fb[s], LANE_A_EVEN);
            end
         end
      end else begin
         unique case (t)
            TAPS_2: begin
               o[0] = ph ? bv[0] : rv[0]; // R4
               o[1] = ph ? '0 : gv[0]; // R4 R20
            end
            TAPS_6: begin
               o[0] = rv[0]; // R21
               o[1] = gv[0];
               o[2] = bv[0];
               o[3] = rv[1];
               o[4] = gv[1];
               o[5] = bv[1];
            end
            TAPS_8: begin
               o[0] = rv[0]; // R6
               o[1] = gv[0];
               o[2] = bv[0];
               o[4] = rv[1];
               o[5] = gv[1];
               o[6] = bv[1];
            end
            default: begin
               o[0] = rv[0]; // R17 R5 R21
               o[1] = gv[0];
               o[2] = bv[0];
            end
         endcase
      end
      for (int i = 0; i < 8; i++) begin
         o[i] = scale(o[i], d); // R1 R8
      end
      return o;
   endfunction

   lcs_line_mem #(
      .AW (AW),
      .DW (WORD_W)
   ) u_mem (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (mem_we),
      .waddr   (r.wr_addr),
      .wdata   ({sen_line_b, sen_line_a}),
      .raddr   (mem_raddr),
      .rdata   (mem_rdata)
   );

   always_comb begin
      logic            trig;
      logic            tick;
      logic [WW-1:0]   len;
      logic [WW-1:0]   base;
      logic [2:0]      kw;
      logic [WW-1:0]   w_n;
      logic [7:0]      fv_even;
      logic [7:0]      ba;
      n         = r;
      mem_we    = 1'b0;
      mem_raddr = '0;
      trig      = r.trg_s2 & ~r.trg_d;
      tick      = r.pck_s2 & ~r.pck_d;
      len       = r.roi_en ? r.roi_len : full_words(r.model); // R2 R3
      base      = r.roi_en ? r.roi_start : '0;
      kw        = words_per_clk(r.mode_raw, r.taps);
      fv_even   = {r.fval_len[7:1], 1'b0};
      ba        = {haddr[7:2], 2'b00};
      w_n       = r.w + {10'h000, kw};
      n.trg_s1  = line_trigger;
      n.trg_s2  = r.trg_s1;
      n.trg_d   = r.trg_s2;
      n.pck_s1  = pixclk_in;
      n.pck_s2  = r.pck_s1;
      n.pck_d   = r.pck_s2;
      n.sen_rd  = 1'b0;
      n.ready_o = 1'b1;

      // Data phase of a write
      if (r.bus_wr && r.bus_addr == REG_CTRL) begin
         n.mode_raw = hwdata[CTRL_RAW_BIT];
         n.taps     = hwdata[CTRL_TAPS_LSB +: 3];
         n.depth    = hwdata[CTRL_DEPTH_LSB +: 2];
         n.roi_en   = hwdata[CTRL_ROI_BIT];
         n.model    = hwdata[CTRL_MODEL_LSB +: 2];
      end
      if (r.bus_wr && r.bus_addr == REG_ROI) begin
         n.roi_start = hwdata[ROI_START_LSB +: WW];
         n.roi_len   = hwdata[ROI_LEN_LSB +: WW];
      end
      if (r.bus_wr && r.bus_addr == REG_EXP) begin
         n.exp_time = hwdata[15:0];
      end
      if (r.bus_wr && r.bus_addr == REG_FVAL) begin
         n.fval_len = hwdata[7:0];
      end
      if (r.bus_wr && r.bus_addr == REG_STAT && hwdata[STAT_MISS_BIT]) begin
         n.missed = 1'b0;
      end

      // Address phase: read data is prepared here for the following data phase
      n.bus_wr = 1'b0;
      if (hsel && hready && htrans[1]) begin
         n.bus_wr   = hwrite && haddr[31:8] == 24'h000000;
         n.bus_addr = ba;
         n.rdata    = '0;
         if (!hwrite && haddr[31:8] == 24'h000000) begin
            case (ba)
               REG_CTRL: n.rdata = {23'h0, r.model, r.roi_en, r.depth, r.taps, r.mode_raw};
               REG_ROI:  n.rdata = {3'h0, r.roi_len, 3'h0, r.roi_start};
               REG_EXP:  n.rdata = {16'h0, r.exp_time};
               REG_FVAL: n.rdata = {24'h0, r.fval_len};
               REG_STAT: n.rdata = {26'h0, r.missed, r.next_b, r.fval,
                                    r.st == ST_SEND || r.st == ST_TAIL, r.expose,
                                    r.st != ST_IDLE};
               default:  n.rdata = '0;
            endcase
         end
      end

      if (!r.mode_raw) begin
         n.next_b = 1'b0;
      end

      // Triggers while busy are dropped and flagged; the set beats a clear
      if (trig && r.st != ST_IDLE) begin
         n.missed = 1'b1;
      end

      unique case (r.st)
         ST_IDLE: begin
            if (trig) begin
               if (r.mode_raw && r.next_b) begin
                  n.line_b   = 1'b1; // R12
                  n.next_b   = 1'b0;
                  n.st       = ST_SEND;
                  n.w        = '0;
                  n.ph       = 1'b0;
                  n.primed   = 1'b0;
                  n.first    = 1'b1;
                  n.fetching = 1'b1;
                  n.fcnt     = '0;
               end else begin
                  n.line_b = 1'b0; // R11 R10
                  n.next_b = r.mode_raw; // R9
                  n.expose = 1'b1; // R13
                  n.cnt    = (r.exp_time == 16'h0000) ? 16'h0001 : r.exp_time;
                  n.st     = ST_EXPOSE;
               end
            end
         end
         ST_EXPOSE: begin
            if (r.cnt == 16'h0001) begin
               n.expose  = 1'b0;
               n.sen_rd  = 1'b1;
               n.wr_addr = '0;
               n.st      = ST_READ;
            end else begin
               n.cnt = r.cnt - 16'h0001;
            end
         end
         ST_READ: begin
            if (sen_valid) begin
               mem_we = 1'b1; // R11
               if ({1'b0, r.wr_addr} == full_words(r.model) - 13'h0001) begin
                  n.st       = ST_SEND;
                  n.w        = '0;
                  n.ph       = 1'b0;
                  n.primed   = 1'b0;
                  n.first    = 1'b1;
                  n.fetching = 1'b1;
                  n.fcnt     = '0;
               end else begin
                  n.wr_addr = r.wr_addr + 12'h001;
               end
            end
         end
         ST_SEND: begin
            n.cap_v = 1'b0;
            if (r.cap_v) begin
               n.fb[r.cap_slot] = r.cap_in ? mem_rdata : '0;
            end
            if (r.fetching) begin
               if (r.fcnt < kw) begin
                  mem_raddr  = 12'(base + r.w + {10'h000, r.fcnt});
                  n.cap_v    = 1'b1;
                  n.cap_slot = r.fcnt[1:0];
                  n.cap_in   = (r.w + {10'h000, r.fcnt}) < len;
                  n.fcnt     = r.fcnt + 3'h1;
               end else if (!r.cap_v) begin
                  n.fetching = 1'b0;
                  n.primed   = 1'b1;
               end
            end
            if (tick && r.primed) begin
               n.tap   = compose(r.mode_raw, r.line_b, r.taps, r.ph, r.fb, r.depth);
               n.lval  = 1'b1; // R7
               n.dval  = 1'b1; // R20
               n.first = 1'b0;
               if (r.first && r.mode_raw && !r.line_b && !r.fval && fv_even != 8'h00) begin
                  n.fval   = 1'b1; // R18
                  n.fcount = '0;
               end
               if (!r.mode_raw && r.taps == TAPS_2 && !r.ph) begin
                  n.ph = 1'b1; // R4
               end else begin
                  n.ph = 1'b0;
                  if (w_n >= len) begin
                     n.st = ST_TAIL;
                  end else begin
                     n.w        = w_n;
                     n.primed   = 1'b0;
                     n.fetching = 1'b1;
                     n.fcnt     = '0;
                  end
               end
            end
         end
         ST_TAIL: begin
            if (tick) begin
               n.lval = 1'b0;
               n.dval = 1'b0;
               n.tap  = '0;
               n.st   = ST_IDLE;
               if (r.fval) begin
                  if (r.fcount + 8'h01 >= fv_even) begin
                     n.fval   = 1'b0; // R19
                     n.fcount = '0;
                  end else begin
                     n.fcount = r.fcount + 8'h01;
                  end
               end
            end
         end
      endcase

      if (fv_even == 8'h00) begin
         n.fval = 1'b0; // R19
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r          <= '0;
         r.st       <= ST_IDLE;
         r.ready_o  <= 1'b1;
         r.taps     <= TAPS_RST;
         r.depth    <= DEPTH_RST;
         r.model    <= MODEL_RST;
         r.exp_time <= EXP_RST;
         r.fval_len <= FVAL_RST;
      end else begin
         r <= n;
      end
   end

   assign hreadyout   = r.ready_o;
   assign hrdata      = r.rdata;
   assign hresp       = r.bus_wr & 1'b0;
   assign sen_expose  = r.expose;
   assign sen_read    = r.sen_rd;
   assign tap_zero    = r.tap[0];
   assign tap_one     = r.tap[1];
   assign tap_two     = r.tap[2];
   assign tap_three   = r.tap[3];
   assign tap_four    = r.tap[4];
   assign tap_five    = r.tap[5];
   assign tap_six     = r.tap[6];
   assign tap_seven   = r.tap[7];
   assign line_valid  = r.lval;
   assign data_valid  = r.dval;
   assign frame_valid = r.fval;

endmodule

`default_nettype wire

//--- logic/lcs_line_mem.sv
// Line buffer holding both sensor lines as packed pixel pairs
`timescale 1ns/1ps
`default_nettype none

module lcs_line_mem #(
   parameter int AW = 12,
   parameter int DW = 48
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Read data always leaves through a register, one cycle after the address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule

`default_nettype wire

//--- sim/lcs_seq_asserts.sv
// Port checks for the colour line-scan output sequencer
`timescale 1ns/1ps
`default_nettype none

module lcs_seq_asserts
   import lcs_pkg::*;
(
   input wire logic             hclk,
   input wire logic             hresetn,
   input wire logic             hreadyout,
   input wire logic             hresp,
   input wire logic             line_trigger,
   input wire logic             pixclk_in,
   input wire logic             sen_expose,
   input wire logic             sen_read,
   input wire logic [PIX_W-1:0] tap_zero,
   input wire logic [PIX_W-1:0] tap_three,
   input wire logic             line_valid,
   input wire logic             data_valid,
   input wire logic             frame_valid
);
   logic [1:0] pk_r;
   logic [3:0] since_r;

   // Cycles since the link clock was last seen rising
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pk_r    <= 2'h0;
         since_r <= 4'hf;
      end else begin
         pk_r <= {pk_r[0], pixclk_in};
         if (pk_r == 2'h1)
            since_r <= 4'h0;
         else if (since_r != 4'hf)
            since_r <= since_r + 4'h1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay)
      else $error("bus answer not zero-wait okay");
   property p_pair; data_valid == line_valid; endproperty
   a_pair: assert property (p_pair)
      else $error("data valid differs from line valid");
   property p_align; !$stable({tap_zero, tap_three, line_valid, frame_valid}) |-> since_r < 4'h6;
   endproperty
   a_align: assert property (p_align)
      else $error("link output changed away from a pixel clock edge");
   property p_fv_rise; $rose(frame_valid) |-> $rose(line_valid); endproperty
   a_fv_rise: assert property (p_fv_rise)
      else $error("frame valid rose without a new line");
   property p_fv_fall; $fell(frame_valid) |-> $fell(line_valid); endproperty
   a_fv_fall: assert property (p_fv_fall)
      else $error("frame valid fell inside a line");
   property p_cause; $rose(sen_expose) |-> $past(line_trigger, 3); endproperty
   a_cause: assert property (p_cause)
      else $error("exposure without a trigger");
   property p_rd_after; $rose(sen_read) |-> $past(sen_expose) || $past(sen_expose, 2); endproperty
   a_rd_after: assert property (p_rd_after)
      else $error("readout not after the common exposure");
   property p_rd_pulse; sen_read |=> !sen_read; endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("readout request longer than one cycle");

   c_frame: cover property ($rose(frame_valid));
   c_expose: cover property ($fell(sen_expose) ##[1:2] sen_read);
   c_line: cover property ($fell(line_valid));
endmodule

bind lcs_sequencer lcs_seq_asserts u_lcs_seq_asserts (
   .hclk, .hresetn, .hreadyout, .hresp, .line_trigger, .pixclk_in, .sen_expose,
   .sen_read, .tap_zero, .tap_three, .line_valid, .data_valid, .frame_valid
);
`default_nettype wire

//--- sim/lcs_grabber.sv
// Frame grabber model capturing one tap set per pixel clock
`timescale 1ns/1ps
`default_nettype none

module lcs_grabber
   import lcs_pkg::*;
(
   input  wire logic [8*PIX_W-1:0] taps,
   input  wire logic               pixclk,
   input  wire logic               line_valid,
   input  wire logic               data_valid,
   input  wire logic               frame_valid,
   output var  logic [8*PIX_W-1:0] cap,
   output var  logic               cap_fv,
   output var  logic               cap_tog
);
   initial cap_tog = 1'b0;
   // Outputs settle mid-period, so a rising edge sees the last whole period
   always @(posedge pixclk) begin
      if (line_valid && data_valid) begin
         cap     <= taps;
         cap_fv  <= frame_valid;
         cap_tog <= !cap_tog;
      end
   end
endmodule
`default_nettype wire

//--- sim/tb_line_scan_color_output_sequencer.sv
// Self-checking bench for the colour line-scan output sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_line_scan_color_output_sequencer
   import lcs_pkg::*;
;
   typedef struct {
      logic [8*PIX_W-1:0] d;
      logic [8*PIX_W-1:0] m;
      logic               fc;
      logic               fv;
   } lcs_exp_t;
   logic               hclk = 1'b0;
   logic               hresetn = 1'b0;
   logic               hsel = 1'b0;
   logic               hwrite = 1'b0;
   logic [1:0]         htrans = 2'h0;
   logic [2:0]         hsize = 3'h2;
   logic [31:0]        haddr = 32'h0;
   logic [31:0]        hwdata = 32'h0;
   logic               line_trigger = 1'b0;
   logic               pixclk = 1'b0;
   logic               sen_valid = 1'b0;
   logic [2*PIX_W-1:0] sa = '0;
   logic [2*PIX_W-1:0] sb = '0;
   logic               hreadyout, hresp, sen_expose, sen_read, cap_fv, cap_tog;
   logic               line_valid, data_valid, frame_valid;
   logic [31:0]        hrdata;
   logic [PIX_W-1:0]   t [8];
   logic [8*PIX_W-1:0] cap;
   logic [PIX_W-1:0]   ra [1024], ga [1024], gb [1024], bb [1024];
   logic [PIX_W-1:0]   sq [$];
   lcs_exp_t           q [$];
   int                 tn_tab [5] = '{2, 3, 4, 6, 8};
   int                 n_errors = 0, cmp_count = 0, n_reads = 0, dsh = 0;

   always #12.5 hclk = !hclk;
   initial begin
      #7;
      forever #100 pixclk = !pixclk;
   end
   always @(posedge sen_read) n_reads++;

   lcs_sequencer u_lcs_sequencer (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .line_trigger, .pixclk_in(pixclk),
      .sen_valid, .sen_line_a(sa), .sen_line_b(sb), .sen_expose, .sen_read,
      .tap_zero(t[0]), .tap_one(t[1]), .tap_two(t[2]), .tap_three(t[3]), .tap_four(t[4]),
      .tap_five(t[5]), .tap_six(t[6]), .tap_seven(t[7]), .line_valid, .data_valid, .frame_valid
   );
   lcs_grabber u_lcs_grabber (
      .taps({t[7], t[6], t[5], t[4], t[3], t[2], t[1], t[0]}), .pixclk, .line_valid,
      .data_valid, .frame_valid, .cap, .cap_fv, .cap_tog
   );

   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input logic [8*PIX_W-1:0] s, input logic [8*PIX_W-1:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task tmo(input int i, input int lim);
      if (i >= lim) begin
         n_errors++;
         test_done;
      end
   endtask

   task rdy;
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            break;
      end
      tmo(i, 50);
   endtask

   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      rdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy;
      rd = hrdata;
   endtask

   // Kind 0 is one RGB line, 1 a raw line A with exposure, 2 the buffered line B
   task shot(input int kind, input int tn, input int nw);
      int i;
      int k;
      int j;
      logic [12:0] sum;
      logic [31:0] rd;
      lcs_exp_t    e;
      for (k = 0; k < 1024 && kind != 2; k++) begin
         ra[k] = PIX_W'($urandom);
         ga[k] = PIX_W'($urandom);
         gb[k] = PIX_W'($urandom);
         bb[k] = PIX_W'($urandom);
      end
      for (k = 0; k < nw; k++) begin
         sum = {1'b0, ga[k]} + gb[k] + 13'h1;
         if (kind == 0)
            sq = {sq, ra[k], sum[12:1], bb[k]};
         if (kind == 0 && tn % 3 != 0)
            sq.push_back('0);
         if (kind == 1)
            sq = {sq, ra[k], ga[k]};
         if (kind == 2)
            sq = {sq, gb[k], bb[k]};
      end
      while (sq.size() != 0) begin
         e = '{d: '0, m: '0, fc: kind != 0, fv: 1'b1};
         for (j = 0; j < tn; j++) begin
            e.m[j*PIX_W +: PIX_W] = '1;
            if (sq.size() != 0)
               e.d[j*PIX_W +: PIX_W] = sq.pop_front() >> dsh;
         end
         q.push_back(e);
      end
      line_trigger <= 1'b1;
      repeat (2) @(posedge hclk);
      line_trigger <= 1'b0;
      if (kind != 2) begin
         for (i = 0; i < 400 && sen_read !== 1'b1; i++)
            @(posedge hclk);
         tmo(i, 400);
         for (k = 0; k < 1024; k++) begin
            sen_valid <= 1'b1;
            sa <= {ga[k], ra[k]};
            sb <= {bb[k], gb[k]};
            @(posedge hclk);
         end
         sen_valid <= 1'b0;
         sa <= ~sa;
         sb <= ~sb;
      end
      for (i = 0; i < 6000; i++) begin
         ahb(1'b0, REG_STAT, 32'h0, rd);
         if (rd[0] === 1'b0 && q.size() == 0)
            break;
      end
      tmo(i, 6000);
      chk(q.size(), 0);
      $display("test done: kind %0d taps %0d words %0d", kind, tn, nw);
   endtask

   always @(cap_tog) begin
      lcs_exp_t e;
      #1;
      if (hresetn === 1'b1 && q.size() == 0)
         chk('0, '1);
      else if (hresetn === 1'b1) begin
         e = q.pop_front();
         chk(cap & e.m, e.d);
         if (e.fc)
            chk(cap_fv, e.fv);
      end
   end

   initial begin
      int c;
      int k;
      logic [31:0] rd;
      void'($urandom(32'hd656c2bf));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, REG_CTRL, 32'h0, rd);
      chk(rd, 32'h124);
      ahb(1'b0, REG_EXP, 32'h0, rd);
      chk(rd, 32'h64);
      ahb(1'b0, REG_FVAL, 32'h0, rd);
      chk(rd, 32'h2);
      ahb(1'b0, 32'h40, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b1, REG_EXP, 32'h4, rd);
      ahb(1'b1, REG_ROI, 32'h0004_0000, rd);
      for (c = 0; c < 5; c++) begin
         dsh = 4 - 2 * (c % 3);
         ahb(1'b1, REG_CTRL, 32'h40 | ((c % 3) << 4) | (c << 1), rd);
         shot(0, tn_tab[c], 4);
      end
      dsh = 0;
      ahb(1'b1, REG_CTRL, 32'h28, rd);
      shot(0, 8, 1024);
      ahb(1'b1, REG_CTRL, 32'h65, rd);
      k = n_reads;
      shot(1, 4, 4);
      shot(2, 4, 4);
      chk(n_reads - k, 1);
      test_done;
   end
endmodule
`default_nettype wire
